// [flash_prot_pkg.sv]
`default_nettype none
package flash_prot_pkg;

  localparam int ADDR_W = 26;
  localparam int DQ_W = 16;

  // bus clock and flash timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ACC_NS = 100;
  localparam int SYNC_CYC = 3;
  localparam logic [2:0] READ_CYC =
    3'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC + 1);
  localparam int UNLOCK_GAP_NS = 6000;
  localparam logic [6:0] UNLOCK_CYC =
    7'((UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // flash command addresses and data
  localparam logic [ADDR_W-1:0] ADDR_555 = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_2AA = 26'h00002AA;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h0000000;
  localparam logic [DQ_W-1:0] DATA_AA = 16'h00AA;
  localparam logic [DQ_W-1:0] DATA_55 = 16'h0055;
  localparam logic [DQ_W-1:0] DATA_A0 = 16'h00A0;
  localparam logic [DQ_W-1:0] DATA_90 = 16'h0090;
  localparam logic [DQ_W-1:0] DATA_00 = 16'h0000;
  localparam logic [DQ_W-1:0] DATA_80 = 16'h0080;
  localparam logic [DQ_W-1:0] DATA_30 = 16'h0030;
  localparam logic [DQ_W-1:0] DATA_25 = 16'h0025;
  localparam logic [DQ_W-1:0] DATA_03 = 16'h0003;
  localparam logic [DQ_W-1:0] DATA_29 = 16'h0029;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_PW_LO = 8'h0C;
  localparam logic [7:0] REG_PW_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RD_LO = 8'h18;
  localparam logic [7:0] REG_RD_HI = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_LOAD = 3'h1,
    S_SETUP = 3'h2,
    S_STROBE = 3'h3,
    S_RELEASE = 3'h4,
    S_READ = 3'h5
  } seq_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ENTER = 4'h1,
    OP_EXIT = 4'h2,
    OP_SET_NV = 4'h3,
    OP_CLEAR_NV = 4'h4,
    OP_PROG_PW = 4'h5,
    OP_LOCK_PROG = 4'h6,
    OP_READ = 4'h7,
    OP_READ_PW = 4'h8,
    OP_UNLOCK = 4'h9
  } op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
    logic rd;
    logic last;
  } step_t;

  typedef struct packed {
    seq_state_t st;
    op_t op;
    logic [2:0] idx;
    logic [2:0] wait_cnt;
    logic [7:0] code;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [63:0] pw;
    logic [63:0] rbuf;
    logic refused;
    logic [6:0] gap;
    logic [ADDR_W-1:0] f_addr;
    logic [DQ_W-1:0] f_dout;
    logic f_dq_oe_n;
    logic f_ce_n;
    logic f_oe_n;
    logic f_we_n;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{st: S_IDLE, op: OP_NONE,
    f_dq_oe_n: 1'b1, f_ce_n: 1'b1, f_oe_n: 1'b1, f_we_n: 1'b1,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  typedef struct packed {
    logic [DQ_W-1:0] s1;
    logic [DQ_W-1:0] s2;
    logic [DQ_W-1:0] s3;
    logic [DQ_W-1:0] val;
  } sync_t;

  localparam sync_t SYNC_RESET = '{default: '0};

endpackage
`default_nettype wire

// [dq_sync.sv]
`default_nettype none
module dq_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [flash_prot_pkg::DQ_W-1:0] pin_in,
  output wire logic [flash_prot_pkg::DQ_W-1:0] value
);
  flash_prot_pkg::sync_t q, d;

  // three stages; accept once stages two and three agree
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.val = q.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= flash_prot_pkg::SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign value = q.val;
endmodule // dq_sync
`default_nettype wire

// [flash_prot_host.sv]
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module flash_prot_host (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,
  output wire logic [1:0] s_axi_bresp,
  output wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0] s_axi_rresp,
  output wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output wire logic [flash_prot_pkg::ADDR_W-1:0] flash_addr,
  output wire logic [flash_prot_pkg::DQ_W-1:0] flash_dq_out,
  input wire logic [flash_prot_pkg::DQ_W-1:0] flash_dq_in,
  output wire logic flash_dq_oe_n,
  output wire logic flash_ce_n,
  output wire logic flash_oe_n,
  output wire logic flash_we_n
);
  flash_prot_pkg::ctrl_t q, d;
  logic [flash_prot_pkg::DQ_W-1:0] dq_value;

  dq_sync u_dq_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in(flash_dq_in),
    .value(dq_value)
  );

  function automatic logic [15:0] pw_word(input logic [63:0] pw,
                                          input logic [1:0] k);
    pw_word = pw[{k, 4'h0} +: 16];
  endfunction

  function automatic flash_prot_pkg::step_t step_of(
      input flash_prot_pkg::ctrl_t c);
    flash_prot_pkg::step_t s;
    logic [1:0] k;
    s = '{addr: flash_prot_pkg::ADDR_ZERO, data: flash_prot_pkg::DATA_00,
          rd: 1'b0, last: 1'b1};
    k = 2'(c.idx - 3'h2);
    unique case (c.op)
      flash_prot_pkg::OP_ENTER: begin
        s.last = (c.idx == 3'h2);
        s.addr = (c.idx == 3'h1) ? flash_prot_pkg::ADDR_2AA
                                 : flash_prot_pkg::ADDR_555;
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_AA :
                 (c.idx == 3'h1) ? flash_prot_pkg::DATA_55 : {8'h00, c.code};
      end
      flash_prot_pkg::OP_EXIT: begin
        s.last = (c.idx == 3'h1);
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_90
                                 : flash_prot_pkg::DATA_00;
      end
      flash_prot_pkg::OP_SET_NV: begin
        s.last = (c.idx == 3'h1);
        s.addr = (c.idx == 3'h0) ? flash_prot_pkg::ADDR_ZERO : c.addr;
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_A0
                                 : flash_prot_pkg::DATA_00;
      end
      flash_prot_pkg::OP_CLEAR_NV: begin
        s.last = (c.idx == 3'h1);
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_80
                                 : flash_prot_pkg::DATA_30;
      end
      flash_prot_pkg::OP_PROG_PW: begin
        s.last = (c.idx == 3'h1);
        s.addr = (c.idx == 3'h0) ? flash_prot_pkg::ADDR_ZERO
                                 : {24'h000000, c.addr[1:0]};
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_A0
                                 : pw_word(c.pw, c.addr[1:0]);
      end
      flash_prot_pkg::OP_LOCK_PROG: begin
        s.last = (c.idx == 3'h1);
        s.data = (c.idx == 3'h0) ? flash_prot_pkg::DATA_A0 : c.wdata;
      end
      flash_prot_pkg::OP_READ: begin
        s.rd = 1'b1;
        s.addr = c.addr;
      end
      flash_prot_pkg::OP_READ_PW: begin
        s.rd = 1'b1;
        s.last = (c.idx == 3'h3);
        s.addr = {24'h000000, c.idx[1:0]};
      end
      flash_prot_pkg::OP_UNLOCK: begin
        s.last = (c.idx == 3'h6);
        if (c.idx == 3'h0) begin
          s.data = flash_prot_pkg::DATA_25;
        end else if (c.idx == 3'h1) begin
          s.data = flash_prot_pkg::DATA_03;
        end else if (c.idx == 3'h6) begin
          s.data = flash_prot_pkg::DATA_29;
        end else begin
          s.addr = {24'h000000, k};
          s.data = pw_word(c.pw, k);
        end
      end
      default: begin
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input flash_prot_pkg::ctrl_t c);
    unique case (a)
      flash_prot_pkg::REG_CTRL: reg_read = {16'h0000, c.code, 4'h0, c.op};
      flash_prot_pkg::REG_ADDR: reg_read = {6'h00, c.addr};
      flash_prot_pkg::REG_WDATA: reg_read = {16'h0000, c.wdata};
      flash_prot_pkg::REG_PW_LO: reg_read = c.pw[31:0];
      flash_prot_pkg::REG_PW_HI: reg_read = c.pw[63:32];
      flash_prot_pkg::REG_STATUS: reg_read = {28'h0000000, c.rbuf[0],
        c.gap != 7'h00, c.refused, c.st != flash_prot_pkg::S_IDLE};
      flash_prot_pkg::REG_RD_LO: reg_read = c.rbuf[31:0];
      flash_prot_pkg::REG_RD_HI: reg_read = c.rbuf[63:32];
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= flash_prot_pkg::REG_RD_HI);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    return old;
  endfunction

  function automatic logic op_ok(input logic [3:0] v);
    op_ok = (v >= 4'h1) && (v <= 4'h9);
  endfunction

  always_comb begin
    flash_prot_pkg::step_t s;
    logic [31:0] wv;
    s = step_of(q);
    wv = 32'h00000000;
    d = q;
    if (q.gap != 7'h00) begin
      d.gap = q.gap - 7'h01;
    end
    // axi write side
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdat = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.awaddr) ? flash_prot_pkg::RESP_OKAY
                                 : flash_prot_pkg::RESP_SLVERR;
      wv = merge(reg_read(q.awaddr, q), q.wdat, q.wstrb);
      if (q.awaddr == flash_prot_pkg::REG_CTRL) begin
        if (q.st != flash_prot_pkg::S_IDLE || !op_ok(wv[3:0]) ||
            (wv[3:0] == flash_prot_pkg::OP_UNLOCK && q.gap != 7'h00)) begin
          d.refused = 1'b1;
        end else begin
          d.refused = 1'b0;
          d.op = flash_prot_pkg::op_t'(wv[3:0]);
          d.code = wv[15:8];
          d.idx = 3'h0;
          d.rbuf = 64'h0000000000000000;
          d.st = flash_prot_pkg::S_LOAD;
        end
      end else if (q.awaddr == flash_prot_pkg::REG_ADDR) begin
        d.addr = wv[25:0];
      end else if (q.awaddr == flash_prot_pkg::REG_WDATA) begin
        d.wdata = wv[15:0];
      end else if (q.awaddr == flash_prot_pkg::REG_PW_LO) begin
        d.pw[31:0] = wv;
      end else if (q.awaddr == flash_prot_pkg::REG_PW_HI) begin
        d.pw[63:32] = wv;
      end
    end
    // axi read side
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = reg_read(s_axi_araddr, q);
      d.rresp = mapped(s_axi_araddr) ? flash_prot_pkg::RESP_OKAY
                                     : flash_prot_pkg::RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // flash cycle sequencer
    unique case (q.st)
      flash_prot_pkg::S_IDLE: begin
        d.wait_cnt = 3'h0;
      end
      flash_prot_pkg::S_LOAD: begin
        d.f_addr = s.addr;
        d.f_ce_n = 1'b0;
        if (s.rd) begin
          d.f_oe_n = 1'b0;
          d.wait_cnt = flash_prot_pkg::READ_CYC;
          d.st = flash_prot_pkg::S_READ;
        end else begin
          d.f_dout = s.data;
          d.f_dq_oe_n = 1'b0;
          d.st = flash_prot_pkg::S_SETUP;
        end
      end
      flash_prot_pkg::S_SETUP: begin
        d.f_we_n = 1'b0;
        d.st = flash_prot_pkg::S_STROBE;
      end
      flash_prot_pkg::S_STROBE: begin
        d.f_we_n = 1'b1;
        d.st = flash_prot_pkg::S_RELEASE;
      end
      flash_prot_pkg::S_READ: begin
        if (q.wait_cnt == 3'h0) begin
          d.rbuf[{q.idx[1:0], 4'h0} +: 16] = dq_value;
          d.f_oe_n = 1'b1;
          d.st = flash_prot_pkg::S_RELEASE;
        end else begin
          d.wait_cnt = q.wait_cnt - 3'h1;
        end
      end
      flash_prot_pkg::S_RELEASE: begin
        d.f_ce_n = 1'b1;
        d.f_dq_oe_n = 1'b1;
        if (s.last) begin
          d.st = flash_prot_pkg::S_IDLE;
          if (q.op == flash_prot_pkg::OP_UNLOCK) begin
            d.gap = flash_prot_pkg::UNLOCK_CYC;
          end
        end else begin
          d.idx = q.idx + 3'h1;
          d.st = flash_prot_pkg::S_LOAD;
        end
      end
      default: begin
        d.st = flash_prot_pkg::S_IDLE;
      end
    endcase
    d.arready = !d.rvalid;
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= flash_prot_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign flash_addr = q.f_addr;
  assign flash_dq_out = q.f_dout;
  assign flash_dq_oe_n = q.f_dq_oe_n;
  assign flash_ce_n = q.f_ce_n;
  assign flash_oe_n = q.f_oe_n;
  assign flash_we_n = q.f_we_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_ENTER_FIRST: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_ENTER && q.idx == 3'h0
    |-> q.f_addr == flash_prot_pkg::ADDR_555 &&
        q.f_dout == flash_prot_pkg::DATA_AA && !q.f_ce_n)
    else $error("enter first cycle wrong");
  AST_ENTER_CODE: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_ENTER && q.idx == 3'h2
    |-> q.f_addr == flash_prot_pkg::ADDR_555 && q.f_dout[7:0] == q.code)
    else $error("enter code cycle wrong");
  AST_WE_ONE_CYCLE: assert property (
    $fell(q.f_we_n) |=> q.f_we_n ##1 q.f_ce_n && q.f_dq_oe_n)
    else $error("write strobe shape wrong");
  AST_EXIT_DATA: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_EXIT
    |-> q.f_dout == (q.idx == 3'h0 ? flash_prot_pkg::DATA_90
                                   : flash_prot_pkg::DATA_00))
    else $error("exit data wrong");
  AST_UNLOCK_END: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_UNLOCK && q.idx == 3'h6
    |-> q.f_dout == flash_prot_pkg::DATA_29 &&
        q.f_addr == flash_prot_pkg::ADDR_ZERO ##2
        q.gap == flash_prot_pkg::UNLOCK_CYC)
    else $error("unlock end or spacing wrong");
  AST_UNLOCK_SPACED: assert property (
    q.st == flash_prot_pkg::S_IDLE && d.st == flash_prot_pkg::S_LOAD &&
    d.op == flash_prot_pkg::OP_UNLOCK |-> q.gap == 7'h00)
    else $error("unlock started too soon");
  AST_PW_WORD: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_PROG_PW && q.idx == 3'h1
    |-> q.f_addr[1:0] == q.addr[1:0] &&
        q.f_dout == pw_word(q.pw, q.addr[1:0]))
    else $error("password word cycle wrong");
  AST_CLEAR_NV: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_CLEAR_NV && q.idx == 3'h1
    |-> q.f_dout == flash_prot_pkg::DATA_30 &&
        q.f_addr == flash_prot_pkg::ADDR_ZERO)
    else $error("clear all second cycle wrong");
  AST_SET_NV: assert property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_SET_NV
    |-> q.f_dout == (q.idx == 3'h0 ? flash_prot_pkg::DATA_A0
                                   : flash_prot_pkg::DATA_00))
    else $error("set bit cycle wrong");
  AST_READ_NO_DRIVE: assert property (
    $fell(q.f_oe_n) |-> q.f_dq_oe_n && q.f_we_n ##[4:6] $rose(q.f_oe_n))
    else $error("read cycle contention or length wrong");

  COV_ENTER: cover property (
    $fell(q.f_we_n) && q.op == flash_prot_pkg::OP_ENTER && q.idx == 3'h2);
  COV_UNLOCK: cover property (
    q.op == flash_prot_pkg::OP_UNLOCK && $rose(q.gap != 7'h00));
  COV_READ_PW: cover property (
    q.op == flash_prot_pkg::OP_READ_PW && $rose(q.f_oe_n) && q.idx == 3'h3);
  COV_REFUSED: cover property ($rose(q.refused));
endmodule // flash_prot_host
`default_nettype wire

// [flash_dev_model.sv]
`default_nettype none
module flash_dev_model #(
  parameter int ACC_NS = 100,
  parameter int PWM_BIT = 2
) (
  input wire logic por_n,
  input wire logic [flash_prot_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_prot_pkg::DQ_W-1:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output wire logic [flash_prot_pkg::DQ_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] lreg, rd, last;
  logic [15:0] pw [4];
  logic [63:0] got;
  logic [7:0] mode, x, d;
  logic [2:0] e, u;
  logic [3:0] nv, vol;
  logic gl;
  realtime t_unl;
  wire logic pwm = !lreg[PWM_BIT];
  wire logic [1:0] blk = addr[17:16];
  wire logic on = !ce_n && !oe_n;
  initial begin
    lreg = 16'hFFFF;
    pw = '{default: 16'hFFFF};
    nv = 4'hF;
    vol = 4'hF;
    gl = 1'b1;
    last = 16'h0000;
    mode = 8'h00;
    x = 8'h00;
    e = 3'h0;
    u = 3'h0;
    t_unl = -6000.0;
  end
  always @(negedge por_n) begin
    gl = !pwm;
    mode = 8'h00;
    x = 8'h00;
    e = 3'h0;
    u = 3'h0;
    vol = 4'hF;
  end
  always @(posedge we_n) begin
    if (!ce_n) begin
      d = dq[7:0];
      if (u != 3'h0) begin
        if (u == 3'h1) u = (d == 8'h03) ? 3'h2 : 3'h0;
        else if (u < 3'h6) begin
          got[16*addr[1:0] +: 16] = dq;
          u = u + 3'h1;
        end else begin
          if (d == 8'h29 && got == {pw[3], pw[2], pw[1], pw[0]}) gl = 1'b1;
          t_unl = $realtime;
          u = 3'h0;
        end
      end else if (mode == 8'h00) begin
        if (e == 3'h0 && addr[11:0] == 12'h555 && d == 8'hAA) e = 3'h1;
        else if (e == 3'h1 && addr[11:0] == 12'h2AA && d == 8'h55) e = 3'h2;
        else if (e == 3'h2 && addr[11:0] == 12'h555) begin
          mode = d;
          e = 3'h0;
        end else e = 3'h0;
      end else if (x == 8'h90) begin
        if (d == 8'h00) mode = 8'h00;
        x = 8'h00;
      end else if (x == 8'hA0) begin
        if (mode == 8'h40) lreg = lreg & dq;
        if (mode == 8'h60 && !pwm) pw[addr[1:0]] = dq;
        if (mode == 8'hC0 && gl && d == 8'h00) nv[blk] = 1'b0;
        x = 8'h00;
      end else if (x == 8'h80) begin
        if (mode == 8'hC0 && d == 8'h30 && addr == '0 && gl) nv = 4'hF;
        x = 8'h00;
      end else if (mode == 8'h60 && d == 8'h25 && addr == '0) begin
        if ($realtime - t_unl >= 6000.0) u = 3'h1;
      end else x = d;
    end
  end
  always_comb begin
    case (mode)
      8'h40: rd = lreg;
      8'h60: rd = pwm ? 16'h0000 : pw[addr[1:0]];
      8'hC0: rd = {15'h0, nv[blk]};
      8'h90: rd = {15'h0, ~(nv[blk] & vol[blk])};
      default: rd = addr[15:0];
    endcase
  end
  always @(posedge oe_n) last = rd;
  assign #(ACC_NS) dq_out = on ? rd : ~last;
endmodule // flash_dev_model
`default_nettype wire

// [flash_prot_host_tb.sv]
`default_nettype none
module flash_prot_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] B1 = 32'h00010000;
  localparam logic [31:0] B2 = 32'h00020000;
  localparam logic [63:0] PW = 64'h0F1E2D3C4B5A6978;
  logic clock, reset_n, por_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, br, rr;
  logic [flash_prot_pkg::ADDR_W-1:0] faddr;
  logic [15:0] hdq, ddq, dq;
  logic dq_oe_n, ce_n, oe_n, we_n;
  int bad_count, checked, cyc;
  assign dq = dq_oe_n ? ddq : hdq;
  flash_prot_host i_dut (.clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(faddr),
    .flash_dq_out(hdq), .flash_dq_in(dq), .flash_dq_oe_n(dq_oe_n),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  flash_dev_model i_dev (.por_n(por_n), .addr(faddr), .dq(dq),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(ddq));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clock);
    ta = 1'b1;
    tw = 1'b1;
    tb = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ta || tw || tb) begin
      @(posedge clock);
      if (ta && awready) begin
        ta = 1'b0;
        awvalid <= 1'b0;
      end
      if (tw && wready) begin
        tw = 1'b0;
        wvalid <= 1'b0;
      end
      if (tb && bvalid) begin
        tb = 1'b0;
        br = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    @(posedge clock);
    ta = 1'b1;
    tr = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (tr) begin
      @(posedge clock);
      if (ta && arready) begin
        ta = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        tr = 1'b0;
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(rv, exp);
  endtask
  task automatic op(input logic [3:0] o, input logic [7:0] code);
    axw(flash_prot_pkg::REG_CTRL, {16'h0, code, 4'h0, o});
    do axr(flash_prot_pkg::REG_STATUS); while (rv[0] !== 1'b0);
  endtask
  task automatic at(input logic [31:0] a, input logic [3:0] o);
    axw(flash_prot_pkg::REG_ADDR, a);
    op(o, 8'h00);
  endtask
  task automatic frd(input logic [31:0] a, input logic [31:0] exp);
    at(a, 4'h7);
    rdc(flash_prot_pkg::REG_RD_LO, exp);
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, bad_count, checked} = '0;
    wstrb = 4'hF;
    por_n = 1'b1;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rdc(flash_prot_pkg::REG_STATUS, 32'h0);
    axr(8'h20);
    chk({30'h0, rr}, {30'h0, flash_prot_pkg::RESP_SLVERR});
    axw(8'h24, 32'h0);
    chk({30'h0, br}, {30'h0, flash_prot_pkg::RESP_SLVERR});
    axw(flash_prot_pkg::REG_CTRL, 32'h0000000F);
    rdc(flash_prot_pkg::REG_STATUS, 32'h2);
    op(4'h1, 8'hC0);
    at(B1, 4'h3);
    frd(B1, 32'h0);
    frd(B2, 32'h1);
    op(4'h2, 8'h00);
    op(4'h1, 8'h90);
    frd(B1, 32'h1);
    rdc(flash_prot_pkg::REG_STATUS, 32'h8);
    frd(B2, 32'h0);
    op(4'h2, 8'h00);
    op(4'h1, 8'hC0);
    at(32'h0, 4'h4);
    frd(B1, 32'h1);
    at(B2, 4'h3);
    op(4'h2, 8'h00);
    axw(flash_prot_pkg::REG_PW_LO, PW[31:0]);
    axw(flash_prot_pkg::REG_PW_HI, PW[63:32]);
    op(4'h1, 8'h60);
    for (int n = 0; n < 4; n++) at(n, 4'h5);
    op(4'h8, 8'h00);
    rdc(flash_prot_pkg::REG_RD_LO, PW[31:0]);
    rdc(flash_prot_pkg::REG_RD_HI, PW[63:32]);
    op(4'h2, 8'h00);
    op(4'h1, 8'h40);
    axw(flash_prot_pkg::REG_WDATA, 32'h0000FFFB);
    op(4'h6, 8'h00);
    frd(32'h0, 32'h0000FFFB);
    op(4'h2, 8'h00);
    axw(flash_prot_pkg::REG_PW_LO, 32'h0);
    op(4'h1, 8'h60);
    at(32'h0, 4'h5);
    op(4'h8, 8'h00);
    rdc(flash_prot_pkg::REG_RD_LO, 32'h0);
    @(posedge clock);
    por_n <= 1'b0;
    @(posedge clock);
    por_n <= 1'b1;
    op(4'h1, 8'h60);
    op(4'h9, 8'h00);
    op(4'h9, 8'h00);
    axr(flash_prot_pkg::REG_STATUS);
    chk({31'h0, rv[1]}, 32'h1);
    chk({31'h0, rv[2]}, 32'h1);
    repeat (70) @(posedge clock);
    op(4'h2, 8'h00);
    op(4'h1, 8'hC0);
    at(32'h0, 4'h4);
    frd(B2, 32'h0);
    op(4'h2, 8'h00);
    axw(flash_prot_pkg::REG_PW_LO, PW[31:0]);
    op(4'h1, 8'h60);
    op(4'h9, 8'h00);
    op(4'h2, 8'h00);
    op(4'h1, 8'hC0);
    at(32'h0, 4'h4);
    frd(B2, 32'h1);
    op(4'h2, 8'h00);
    wrap_up();
  end
endmodule // flash_prot_host_tb
`default_nettype wire
